/* rtl/prs_pkg.sv */
// constants and carrier types for the ratio select and scale block
// assumes a 20 MHz system clock and a classic wishbone register bus
package prs_pkg;
    localparam int          DAT_W          = 32;
    localparam int          ADR_W          = 8;
    // register byte offsets
    localparam logic [7:0]  OFS_RATIO0     = 8'h00;
    localparam logic [7:0]  OFS_RATIO3     = 8'h0c;
    localparam logic [7:0]  OFS_GCFG       = 8'h10;
    localparam logic [7:0]  OFS_MODAL      = 8'h14;
    localparam logic [7:0]  OFS_STATUS     = 8'h18;
    localparam logic [7:0]  OFS_EFF        = 8'h1c;
    // global config fields
    localparam int          GCFG_FMT_BIT   = 0;
    localparam int          GCFG_BW_LSB    = 1;
    localparam int          GCFG_PINFN_LSB = 4;
    localparam int          GCFG_LOCK_BIT  = 7;
    localparam int          GCFG_W         = 8;
    // modal config: one nibble per mode
    localparam int          MODAL_SET_W    = 4;
    localparam int          MODAL_AUTO_BIT = 2;
    localparam int          MODAL_W        = 16;
    // reset values
    localparam logic [7:0]  GCFG_RST       = 8'h00;
    localparam logic [15:0] MODAL_RST      = 16'h0000;
    localparam logic [31:0] RATIO_RST      = 32'h0010_0000;
    // encodings
    localparam logic        FMT_HIRES      = 1'b1;
    localparam logic [2:0]  PIN_FN_MANUAL  = 3'h3;
    localparam logic [2:0]  PIN_FN_AUTO    = 3'h5;
    localparam logic [1:0]  RANGE_FAST     = 2'h0;
    localparam logic [1:0]  RANGE_MID      = 2'h1;
    localparam logic [1:0]  RANGE_SLOW     = 2'h2;
    localparam logic [3:0]  BW_WIDE        = 4'h8;
    // rate detector thresholds, internal clocks per reference period
    localparam int          RATE_CNT_W     = 9;
    localparam logic [8:0]  RATE_HI        = 9'h0e0;
    localparam logic [8:0]  RATE_LO        = 9'h060;
    // timing
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          RELOCK_NS      = 800;
    localparam int          RELOCK_CYC     = (RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {LK_RELOCK, LK_ACQUIRE, LK_LOCKED} prs_lock_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } prs_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } prs_wb_rsp_t;

    typedef struct packed {
        logic [31:0] eff;
        logic [19:0] int_part;
        logic [19:0] frac;
        logic        fmt;
    } prs_ratio_t;

    typedef struct packed {
        logic [3:0][31:0] ratios;
        logic [7:0]       gcfg;
        logic [15:0]      modal;
        logic [1:0]       mode;
        logic             ref_prev;
        logic [8:0]       rate_cnt;
        logic [1:0]       range;
        prs_lock_t        lock_st;
        logic [7:0]       relock_cnt;
        logic [3:0]       bw;
        logic             relock;
        logic             locked;
        prs_ratio_t       ratio;
        prs_wb_rsp_t      rsp;
    } prs_state_t;
endpackage : prs_pkg

/* rtl/prs_top.sv */
// ratio select, format and power-of-two scaling for a fractional-n multiplier
// assumes all pins synchronous to clk_i; the synthesizer reports its lock level
//
// Function
// - three-bit setting picks minimum loop bandwidth, 1 Hz up to 128 Hz.
// - bandwidth forced wide while acquiring lock, minimum once locked.
// - each stored ratio is an unsigned 32-bit fixed-point value.
// - four stored ratios; two mode pins pick the addressed one.
// - global format bit selects 12.20 or 20.12 interpretation.
// - 12.20 format: upper 12 bits integer, lower 20 fraction.
// - 20.12 format: upper 20 bits integer, lower 12 fraction.
// - manual scaling works on a copy; stored ratios never change.
// - manual codes 00..11 scale by 0.5, 0.25, 0.125, 0.0625.
// - manual scaling applies only when enabled by the third pin.
// - detector measures internal clock to reference rate, two-bit status.
// - status 00 above 224, 01 from 96 to 224, 10 below 96.
// - auto scaling enabled per mode or overridden by third pin.
// - auto scaling applies on top of manual scaling.
// - effective ratio is user ratio times both modifiers.
// - pin function 011 makes third pin the manual scale enable.
// - pin function 101 makes third pin the auto scale enable.
// - a change on either of the two mode pins drops lock while new settings apply; the third pin does not.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module prs_top #(
    parameter int RELOCK_CYC = prs_pkg::RELOCK_CYC
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire prs_pkg::prs_wb_req_t wb_req_i,
    output var  prs_pkg::prs_wb_rsp_t wb_rsp_o,
    // pins and synthesizer status
    input  wire logic [1:0]           mode_sel_i,
    input  wire logic                 third_mode_pin_i,
    input  wire logic                 ref_clk_i,
    input  wire logic                 synth_locked_i,
    // to synthesizer and digital loop
    output var  prs_pkg::prs_ratio_t  ratio_o,
    output logic [3:0]                loop_bw_o,
    output logic                      relock_o,
    output logic                      locked_o
);

    ////////////////////////////////////////////////////////////////////////
    prs_pkg::prs_state_t q;
    prs_pkg::prs_state_t d;
    logic [31:0]         cur_ratio;
    logic [3:0]          modal_cur;
    logic [2:0]          pin_fn;
    logic                man_en;
    logic                auto_en;
    logic [2:0]          man_sh;
    logic [2:0]          auto_sh;
    logic [31:0]         eff;
    logic                ref_rise;
    logic                wr_acc;
    logic [31:0]         rd_dat;

    function automatic logic is_ratio(input logic [7:0] adr);
        is_ratio = (adr <= prs_pkg::OFS_RATIO3) && (adr[1:0] == 2'h0);
    endfunction : is_ratio

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d         = q;
        // the mode pins address both the ratio and its modal nibble
        cur_ratio = q.ratios[q.mode];
        modal_cur = q.modal[q.mode*prs_pkg::MODAL_SET_W +: prs_pkg::MODAL_SET_W];
        pin_fn    = q.gcfg[prs_pkg::GCFG_PINFN_LSB +: 3];
        man_en    = (pin_fn == prs_pkg::PIN_FN_MANUAL) && third_mode_pin_i;
        if (pin_fn == prs_pkg::PIN_FN_AUTO)
        begin
            auto_en = third_mode_pin_i;
        end
        else
        begin
            auto_en = modal_cur[prs_pkg::MODAL_AUTO_BIT];
        end
        // shift amounts; a disabled modifier shifts by zero
        man_sh  = man_en ? ({1'b0, modal_cur[1:0]} + 3'h1) : 3'h0;
        auto_sh = 3'h0;
        if (auto_en)
        begin
            if (q.range == prs_pkg::RANGE_SLOW)
            begin
                auto_sh = 3'h2;
            end
            else if (q.range == prs_pkg::RANGE_MID)
            begin
                auto_sh = 3'h1;
            end
        end
        // both shifts stack; fraction bits fall off the bottom
        eff = cur_ratio >> (man_sh + auto_sh);

        // rate detector: clocks per reference period, saturating
        ref_rise   = ref_clk_i && !q.ref_prev;
        d.ref_prev = ref_clk_i;
        if (ref_rise)
        begin
            d.rate_cnt = 9'h001;
            if (q.rate_cnt > prs_pkg::RATE_HI)
            begin
                d.range = prs_pkg::RANGE_FAST;
            end
            else if (q.rate_cnt >= prs_pkg::RATE_LO)
            begin
                d.range = prs_pkg::RANGE_MID;
            end
            else
            begin
                d.range = prs_pkg::RANGE_SLOW;
            end
        end
        else if (q.rate_cnt != 9'h1ff)
        begin
            d.rate_cnt = q.rate_cnt + 9'h001;
        end
        else
        begin
            // stalled reference reads as a very slow input
            d.range = prs_pkg::RANGE_FAST;
        end

        // lock sequencing
        d.mode = mode_sel_i;
        if (mode_sel_i != q.mode)
        begin
            d.lock_st    = prs_pkg::LK_RELOCK;
            d.relock_cnt = 8'(RELOCK_CYC);
        end
        else
        begin
            case (q.lock_st)
                prs_pkg::LK_RELOCK:
                begin
                    if (q.relock_cnt <= 8'h01)
                    begin
                        d.lock_st = prs_pkg::LK_ACQUIRE;
                    end
                    d.relock_cnt = (q.relock_cnt == 8'h00) ? 8'h00 : q.relock_cnt - 8'h01;
                end
                prs_pkg::LK_ACQUIRE:
                begin
                    if (synth_locked_i)
                    begin
                        d.lock_st = prs_pkg::LK_LOCKED;
                    end
                end
                default:
                begin
                    if (!synth_locked_i)
                    begin
                        d.lock_st = prs_pkg::LK_ACQUIRE;
                    end
                end
            endcase
        end
        d.relock = (d.lock_st == prs_pkg::LK_RELOCK);
        d.locked = (d.lock_st == prs_pkg::LK_LOCKED);

        // wishbone: one wait state, write lands on the acking edge
        wr_acc  = wb_req_i.cyc && wb_req_i.stb && !q.rsp.ack;
        rd_dat  = 32'h0000_0000;
        if (is_ratio(wb_req_i.adr))
        begin
            rd_dat = q.ratios[wb_req_i.adr[3:2]];
            // one-time storage: frozen once the lock bit is set
            if (wr_acc && wb_req_i.we && !q.gcfg[prs_pkg::GCFG_LOCK_BIT])
            begin
                d.ratios[wb_req_i.adr[3:2]] =
                    merge(q.ratios[wb_req_i.adr[3:2]], wb_req_i.dat, wb_req_i.sel);
            end
        end
        else if (wb_req_i.adr == prs_pkg::OFS_GCFG)
        begin
            rd_dat = {24'h00_0000, q.gcfg};
            if (wr_acc && wb_req_i.we && wb_req_i.sel[0])
            begin
                d.gcfg = wb_req_i.dat[7:0];
                // lock bit cannot be cleared again
                d.gcfg[prs_pkg::GCFG_LOCK_BIT] = wb_req_i.dat[prs_pkg::GCFG_LOCK_BIT]
                                                 | q.gcfg[prs_pkg::GCFG_LOCK_BIT];
            end
        end
        else if (wb_req_i.adr == prs_pkg::OFS_MODAL)
        begin
            rd_dat = {16'h0000, q.modal};
            if (wr_acc && wb_req_i.we && !q.gcfg[prs_pkg::GCFG_LOCK_BIT])
            begin
                d.modal = 16'(merge({16'h0000, q.modal}, wb_req_i.dat, wb_req_i.sel));
            end
        end
        else if (wb_req_i.adr == prs_pkg::OFS_STATUS)
        begin
            rd_dat = {22'h00_0000, q.mode, q.lock_st, q.bw, q.range};
        end
        else if (wb_req_i.adr == prs_pkg::OFS_EFF)
        begin
            rd_dat = q.ratio.eff;
        end
        d.rsp.ack = wr_acc;
        d.rsp.dat = wr_acc ? rd_dat : 32'h0000_0000;

        // bandwidth follows the lock state of the next cycle
        if (d.lock_st == prs_pkg::LK_LOCKED)
        begin
            d.bw = {1'b0, d.gcfg[prs_pkg::GCFG_BW_LSB +: 3]};
        end
        else
        begin
            d.bw = prs_pkg::BW_WIDE;
        end

        // format split for the synthesizer, fraction left aligned
        d.ratio.eff = eff;
        d.ratio.fmt = q.gcfg[prs_pkg::GCFG_FMT_BIT];
        if (q.gcfg[prs_pkg::GCFG_FMT_BIT] == prs_pkg::FMT_HIRES)
        begin
            d.ratio.int_part = {8'h00, eff[31:20]};
            d.ratio.frac     = eff[19:0];
        end
        else
        begin
            d.ratio.int_part = eff[31:12];
            d.ratio.frac     = {eff[11:0], 8'h00};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q            <= '0;
            q.ratios     <= {4{prs_pkg::RATIO_RST}};
            q.gcfg       <= prs_pkg::GCFG_RST;
            q.modal      <= prs_pkg::MODAL_RST;
            q.lock_st    <= prs_pkg::LK_ACQUIRE;
            q.bw         <= prs_pkg::BW_WIDE;
        end
        else
        begin
            q <= d;
        end
    end

    assign wb_rsp_o  = q.rsp;
    assign ratio_o   = q.ratio;
    assign loop_bw_o = q.bw;
    assign relock_o  = q.relock;
    assign locked_o  = q.locked;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // length of one unbroken relock window; a new mode change restarts it
    logic [7:0] relock_run_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (mode_sel_i != q.mode) || !relock_o)
        begin
            relock_run_q <= 8'h00;
        end
        else
        begin
            relock_run_q <= relock_run_q + 8'h01;
        end
    end

    a_bw_wide_acq:   assert property (!locked_o |-> loop_bw_o == prs_pkg::BW_WIDE)
        else $error("loop bandwidth not wide while unlocked");
    a_bw_min_lock:   assert property (locked_o |->
                         loop_bw_o == {1'b0, q.gcfg[prs_pkg::GCFG_BW_LSB +: 3]})
        else $error("loop bandwidth not at minimum setting when locked");
    a_mode_relock:   assert property ((mode_sel_i != q.mode) |=> relock_o && !locked_o)
        else $error("mode change did not drop lock");
    a_relock_hold:   assert property ($fell(relock_o) |-> relock_run_q == 8'(RELOCK_CYC))
        else $error("relock window too short");
    a_range_slow:    assert property ((ref_rise && q.rate_cnt < prs_pkg::RATE_LO) |=>
                         q.range == prs_pkg::RANGE_SLOW)
        else $error("slow range not reported");
    a_range_fast:    assert property ((ref_rise && q.rate_cnt > prs_pkg::RATE_HI) |=>
                         q.range == prs_pkg::RANGE_FAST)
        else $error("fast range not reported");
    a_eff_unmod:     assert property ((!man_en && !auto_en) |=>
                         ratio_o.eff == $past(cur_ratio))
        else $error("unmodified ratio altered");
    a_eff_manual:    assert property ((man_en && !auto_en) |=>
                         ratio_o.eff == ($past(cur_ratio) >> ($past(modal_cur[1:0]) + 1)))
        else $error("manual scale shift wrong");
    a_ratio_frozen:  assert property (q.gcfg[prs_pkg::GCFG_LOCK_BIT] |=> $stable(q.ratios))
        else $error("stored ratio changed after lock");
    a_fmt_hires:     assert property ((ratio_o.fmt == prs_pkg::FMT_HIRES) |->
                         ratio_o.int_part == {8'h00, ratio_o.eff[31:20]})
        else $error("12.20 integer split wrong");
    a_fmt_himul:     assert property ((ratio_o.fmt != prs_pkg::FMT_HIRES) |->
                         ratio_o.int_part == ratio_o.eff[31:12])
        else $error("20.12 integer split wrong");
    a_ack_pulse:     assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");

    c_mode_change:   cover property (mode_sel_i != q.mode);
    c_locked:        cover property ($rose(locked_o));
    c_both_scales:   cover property (man_en && auto_en && q.range == prs_pkg::RANGE_SLOW);
    c_range_mid:     cover property (ref_rise && q.rate_cnt == prs_pkg::RATE_HI);

endmodule : prs_top
`default_nettype wire

/* rtl/prs_top_fix.sv */
// empty companion; no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* testbench/prs_far_model.sv */
// far-side model: reference clock source and synthesizer lock report
// assumes relock_o of the block and a half period set by the bench
`timescale 1ns/1ps
`default_nettype none
module prs_far_model #(
    parameter int LOCK_DLY = 6
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // control from block and bench
    input  wire logic       relock_i,
    input  wire logic [8:0] ref_half_i,
    // to block
    output logic            ref_clk_o,
    output logic            locked_o
);
    int ref_cnt;
    int lock_cnt;
    logic wrap;

    assign wrap = ref_cnt >= int'(ref_half_i) - 1;

    always_ff @(posedge clk_i)
    begin
        ref_cnt <= (rst_i || wrap) ? 0 : ref_cnt + 1;
        ref_clk_o <= rst_i ? 1'b0 : (wrap ? !ref_clk_o : ref_clk_o);
        // lock only some cycles after the forced window, like a settling loop
        lock_cnt <= (rst_i || relock_i) ? 0 : (lock_cnt < LOCK_DLY ? lock_cnt + 1 : lock_cnt);
        locked_o <= !rst_i && !relock_i && lock_cnt == LOCK_DLY;
    end
endmodule : prs_far_model
`default_nettype wire

/* testbench/test_prs_top.sv */
// self-checking bench for the ratio select and scale block
// assumes the far-side model file; 20 MHz clock, wishbone master tasks
`timescale 1ns/1ps
`default_nettype none
module test_prs_top;
    localparam int RLK = 4;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    prs_pkg::prs_wb_req_t wb_req_i = '0;
    prs_pkg::prs_wb_rsp_t wb_rsp_o;
    logic [1:0]           mode_sel_i = 2'h0;
    logic                 third_mode_pin_i = 1'b0;
    logic                 ref_clk_i;
    logic                 synth_locked_i;
    prs_pkg::prs_ratio_t  ratio_o;
    logic [3:0]           loop_bw_o;
    logic                 relock_o;
    logic                 locked_o;
    logic [8:0]           ref_half = 9'h096;
    logic [7:0]           gc = 8'h00;
    logic [31:0]          rdat;
    // low six bits clear so no shift combination truncates
    logic [31:0]          rat [4] = '{32'h0040_0000, 32'h0123_4540, 32'h8000_0000, 32'h00ab_cd00};
    int                   err_total = 0;
    int                   n_compared = 0;

    always #25 clk_i = !clk_i;

    prs_top #(.RELOCK_CYC(RLK)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
        .wb_rsp_o(wb_rsp_o), .mode_sel_i(mode_sel_i), .third_mode_pin_i(third_mode_pin_i),
        .ref_clk_i(ref_clk_i), .synth_locked_i(synth_locked_i), .ratio_o(ratio_o),
        .loop_bw_o(loop_bw_o), .relock_o(relock_o), .locked_o(locked_o));
    prs_far_model i_far (.clk_i(clk_i), .rst_i(rst_i), .relock_i(relock_o),
        .ref_half_i(ref_half), .ref_clk_o(ref_clk_i), .locked_o(synth_locked_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // called just after a rising edge; ends one idle cycle after ack
    // waits for ack as long as it takes; only the watchdog ends a hung wait
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        do
        begin
            @(posedge clk_i);
        end
        while (wb_rsp_o.ack !== 1'b1);
        rdat = wb_rsp_o.dat;
        wb_req_i <= '0;
        @(posedge clk_i);
    endtask : wb

    task automatic wcfg(input logic [7:0] g, input logic [15:0] md, input logic pin);
        gc = g;
        third_mode_pin_i <= pin;
        wb(1'b1, prs_pkg::OFS_GCFG, {24'h0, g});
        wb(1'b1, prs_pkg::OFS_MODAL, {16'h0, md});
    endtask : wcfg

    task automatic chk_eff(input logic [31:0] e);
        repeat (3) @(posedge clk_i);
        chk("eff", ratio_o.eff, e);
    endtask : chk_eff

    task automatic set_mode(input logic [1:0] m);
        int n;
        n = 0;
        mode_sel_i <= m;
        repeat (2) @(posedge clk_i);
        while (relock_o === 1'b1 && n < 40)
        begin
            chk("bw_wide", {28'h0, loop_bw_o}, {28'h0, prs_pkg::BW_WIDE});
            n++;
            @(posedge clk_i);
        end
        chk("relock_len", n, RLK);
        n = 0;
        while (locked_o !== 1'b1 && n < 40)
        begin
            n++;
            @(posedge clk_i);
        end
        chk("bw_min", {28'h0, loop_bw_o}, {29'h0, gc[3:1]});
    endtask : set_mode

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("bw_acq", {28'h0, loop_bw_o}, {28'h0, prs_pkg::BW_WIDE});
        chk("lock_rst", {30'h0, relock_o, locked_o}, 32'h0);
        wb(1'b0, prs_pkg::OFS_RATIO0, '0);
        chk("ratio0_rst", rdat, prs_pkg::RATIO_RST);
        wb(1'b0, prs_pkg::OFS_GCFG, '0);
        chk("gcfg_rst", rdat, 32'h0);
        wb(1'b0, 8'h40, '0);
        chk("unmapped", rdat, 32'h0);
        chk("bw_locked", {28'h0, loop_bw_o}, 32'h0);
        $display("done reset");
    endtask : t_reset

    task automatic t_select();
        for (int i = 0; i < 4; i++)
            wb(1'b1, 8'(4 * i), rat[i]);
        wcfg(8'h0b, 16'h0, 1'b0);
        for (int m = 1; m < 5; m++)
        begin
            set_mode(2'(m));
            chk_eff(rat[m % 4]);
        end
        chk("int_hires", {12'h0, ratio_o.int_part}, {20'h0, rat[0][31:20]});
        chk("frac_hires", {12'h0, ratio_o.frac}, {12'h0, rat[0][19:0]});
        chk("fmt_hires", {31'h0, ratio_o.fmt}, 32'h1);
        set_mode(2'h1);
        // 20.12 only for a ratio above 4096
        wcfg(8'h0a, 16'h0, 1'b0);
        chk_eff(rat[1]);
        chk("int_mult", {12'h0, ratio_o.int_part}, {12'h0, rat[1][31:12]});
        chk("fmt_mult", {31'h0, ratio_o.fmt}, 32'h0);
        chk("frac_mult", {12'h0, ratio_o.frac}, {12'h0, rat[1][11:0], 8'h0});
        set_mode(2'h0);
        $display("done select");
    endtask : t_select

    task automatic t_manual();
        for (int c = 0; c < 4; c++)
        begin
            wcfg(8'h3b, {14'h0, 2'(c)}, 1'b1);
            chk_eff(rat[0] >> (c + 1));
            wcfg(8'h3b, {14'h0, 2'(c)}, 1'b0);
            chk_eff(rat[0]);
        end
        wcfg(8'h0b, 16'h0003, 1'b1);
        chk_eff(rat[0]);
        wb(1'b0, prs_pkg::OFS_RATIO0, '0);
        chk("ratio0_kept", rdat, rat[0]);
        $display("done manual");
    endtask : t_manual

    task automatic t_auto();
        logic [8:0] h [3] = '{9'h096, 9'h050, 9'h01e};
        wcfg(8'h0b, 16'h0004, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            ref_half <= h[i];
            repeat (1000) @(posedge clk_i);
            chk_eff(rat[0] >> i);
            wb(1'b0, prs_pkg::OFS_STATUS, '0);
            chk("range", {30'h0, rdat[1:0]}, i);
        end
        wcfg(8'h3b, 16'h0005, 1'b1);
        chk_eff(rat[0] >> 4);
        wcfg(8'h5b, 16'h0004, 1'b0);
        chk_eff(rat[0]);
        wcfg(8'h5b, 16'h0000, 1'b1);
        chk_eff(rat[0] >> 2);
        wb(1'b0, prs_pkg::OFS_RATIO0, '0);
        chk("ratio0_kept", rdat, rat[0]);
        $display("done auto");
    endtask : t_auto

    // one-time lock: later writes to ratios and the lock bit are refused
    task automatic t_lock();
        wb(1'b1, prs_pkg::OFS_GCFG, 32'h0000_008b);
        wb(1'b1, prs_pkg::OFS_RATIO0, 32'h0000_0000);
        wb(1'b1, prs_pkg::OFS_GCFG, 32'h0000_000b);
        wb(1'b0, prs_pkg::OFS_GCFG, '0);
        chk("gcfg_locked", rdat, 32'h0000_008b);
        wb(1'b0, prs_pkg::OFS_RATIO0, '0);
        chk("ratio0_locked", rdat, rat[0]);
        $display("done lock");
    endtask : t_lock

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_select();
        t_manual();
        t_auto();
        t_lock();
        test_done();
    end

    // whole run needs about 3300 cycles
    initial
    begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        test_done();
    end
endmodule : test_prs_top
`default_nettype wire
